// ---- include/sce_defs.svh ----
// Purpose: Constants for the sheet count evaluator
// Assumes: pclk at 10 MHz
// Notes: Offsets are byte addresses on APB
`ifndef SCE_DEFS_SVH
`define SCE_DEFS_SVH
`define SCE_CLK_HZ 10000000
`define SCE_MEAS_US 2000
`define SCE_MEAS_CYC ((`SCE_CLK_HZ / 1000000) * `SCE_MEAS_US)
`define SCE_OFF_CTRL 12'h000
`define SCE_OFF_STAT 12'h004
`define SCE_OFF_SENSE 12'h008
`define SCE_CTRL_CAL_BIT 0
`define SCE_STAT_ACT_BIT 0
`define SCE_STAT_EDGE_BIT 1
`define SCE_STAT_DBL_BIT 2
`define SCE_STAT_SGL_BIT 3
`define SCE_STAT_OVL_BIT 4
`define SCE_STAT_BUSY_BIT 5
`define SCE_STAT_CAL_BIT 6
`define SCE_CTRL_RST 32'h00000000
`endif

// ---- include/sce_pkg.sv ----
// Purpose: Types for the sheet count evaluator
// Assumes: nothing
// Notes: One-hot measurement states
package sce_pkg;
  typedef enum logic [2:0] {
    SCE_IDLE = 3'b001,
    SCE_MEAS = 3'b010,
    SCE_WIN = 3'b100
  } sce_state_t;
  typedef enum logic [1:0] {
    SCE_NONE = 2'h0,
    SCE_ONE = 2'h1,
    SCE_TWO = 2'h2
  } sce_count_t;
endpackage

// ---- include/sce_sync_if.sv ----
// Purpose: Synchronised control levels and their edges
// Assumes: single pclk domain
// Notes: Carries the sync block output to the evaluator
`timescale 1ns/100ps
interface sce_sync_if;
  logic act;
  logic act_rise;
  logic act_fall;
  logic query;
  logic query_rise;
  logic query_fall;
  logic ovl_rise;
  logic mode;
  logic [1:0] sense;
  modport src (output act, act_rise, act_fall, query, query_rise, query_fall, ovl_rise, mode, sense);
  modport dst (input act, act_rise, act_fall, query, query_rise, query_fall, ovl_rise, mode, sense);
endinterface

// ---- verif/sce_machine.sv ----
// Purpose: Machine controller model
// Assumes: pclk at 10 MHz
// Notes: Tasks are called by the bench
`timescale 1ns/100ps
module sce_machine (
  // Clock
  input wire logic pclk,
  // Pins toward the evaluator
  output logic act,
  output logic pq,
  output logic oq,
  output logic mode,
  output logic [1:0] sense
);
  // ****
  // Pin sequences
  // ****
  // Longer than one full measurement, so the next query is not ignored
  localparam int HOLD = 20100;
  initial begin
    act = 0;
    pq = 0;
    oq = 0;
    mode = 0;
    sense = 2'h0;
  end
  task automatic wait_c(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic power(input logic on, input logic m);
    @(posedge pclk);
    pq <= on & ~m;
    mode <= m;
    sense <= 2'h0;
    wait_c(4);
    act <= on;
    wait_c(10);
    mode <= ~m;
  endtask
  task automatic edge_q(input logic [1:0] n);
    @(posedge pclk);
    sense <= n;
    wait_c(6);
    pq <= 1'b1;
    wait_c(12);
  endtask
  task automatic settle(input logic lvl, input bit full);
    wait_c(full ? HOLD : 40);
    pq <= lvl;
    wait_c(6);
  endtask
  task automatic ovl_q(input logic [1:0] n);
    @(posedge pclk);
    sense <= n;
    wait_c(6);
    oq <= 1'b1;
    wait_c(10);
    oq <= 1'b0;
    wait_c(6);
  endtask
  task automatic win_q(input logic [5:0] seq);
    @(posedge pclk);
    pq <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      sense <= seq[2*i+:2];
      wait_c(20);
    end
    pq <= 1'b1;
    wait_c(12);
  endtask
endmodule // sce_machine

// ---- verif/sce_properties.sv ----
// Purpose: Port checks for the evaluator
// Assumes: pins are held at least 6 cycles
// Notes: Bound to sce_top
`timescale 1ns/100ps
module sce_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Machine pins
  input wire logic activate_in,
  input wire logic overlap_query_in,
  // Results
  input wire logic single_sheet_out,
  input wire logic double_sheet_out,
  input wire logic overlap_fault_out,
  input wire logic ready_out
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_answer: assert property (psel && !penable |=> pready) else $error("no answer");
  a_apb_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_bad_addr: assert property (psel && !penable && paddr > 12'h008 |=> pslverr) else $error("no error");
  a_cal_gate: assert property ($rose(single_sheet_out) || $rose(double_sheet_out) |-> ready_out)
    else $error("result while uncalibrated");
  a_dbl_hold: assert property (activate_in [*4] ##0 double_sheet_out |=> double_sheet_out)
    else $error("double dropped");
  a_deact_clear: assert property ($fell(activate_in) |-> ##[1:4] !double_sheet_out && !single_sheet_out)
    else $error("results kept");
  a_ovl_clear: assert property ($fell(activate_in) |-> ##[1:4] !overlap_fault_out)
    else $error("overlap kept");
  a_ovl_cause: assert property ($rose(overlap_fault_out) |-> $past(overlap_query_in, 2))
    else $error("overlap without query");
endmodule // sce_properties
bind sce_top sce_properties chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .activate_in,
  .overlap_query_in, .single_sheet_out, .double_sheet_out, .overlap_fault_out, .ready_out);

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the evaluator
// Assumes: one APB access cycle
// Notes: Pin results packed as ready, overlap, double, single
`timescale 1ns/100ps
`include "sce_defs.svh"
module tb;
  // ****
  // Bench
  // ****
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, act, pq, oq, mode, sgl, dbl, ovl, rdy;
  logic [1:0] sense;
  logic [32:0] exp_q[$], got;
  bit kind_q[$];
  int num_errors = 0, checked = 0, seed = 18;
  event res_ev;
  initial forever #50 pclk = ~pclk;
  sce_machine m (.pclk(pclk), .act(act), .pq(pq), .oq(oq), .mode(mode), .sense(sense));
  sce_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .activate_in(act), .primary_query_in(pq), .overlap_query_in(oq), .edge_mode_in(mode),
    .sheet_sense_in(sense), .single_sheet_out(sgl), .double_sheet_out(dbl),
    .overlap_fault_out(ovl), .ready_out(rdy));
  task automatic tally(input logic [32:0] g, input logic [32:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_rd(input logic [32:0] e);
    tally(got, e);
  endtask
  task automatic cmp_pin(input logic [32:0] e);
    tally({29'h0, rdy, ovl, dbl, sgl}, e);
  endtask
  task automatic note(input bit k, input logic [32:0] e);
    kind_q.push_back(k);
    exp_q.push_back(e);
    @(negedge pclk);
    -> res_ev;
  endtask
  task automatic pins(input logic [3:0] v);
    note(0, {29'h0, v});
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    got = {pslverr, w ? 32'h0 : prdata};
    psel <= 0;
    penable <= 0;
    note(1, e);
  endtask
  task automatic conclude;
    $display("errors %0d checked %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever begin
    @(res_ev);
    if (kind_q.pop_front()) cmp_rd(exp_q.pop_front());
    else cmp_pin(exp_q.pop_front());
  end
  initial begin
    repeat (50000) @(posedge pclk);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    acc(0, `SCE_OFF_CTRL, 0, {1'b0, `SCE_CTRL_RST});
    acc(0, 12'($random(seed)) | 12'h800, 0, {1'b1, 32'h0});
    acc(1, `SCE_OFF_STAT, $random(seed), {1'b1, 32'h0});
    m.power(1, 1);
    repeat (2) begin
      m.edge_q(2'h1 + 2'($random(seed) & 1));
      pins(4'b0000);
      m.settle(0, 0);
    end
    m.power(0, 1);
    acc(1, `SCE_OFF_CTRL, {31'($random(seed)), 1'b1}, {1'b0, 32'h0});
    acc(0, `SCE_OFF_CTRL, 0, {1'b0, 32'h1});
    m.power(1, 1);
    m.edge_q(2'h1);
    pins(4'b1001);
    acc(0, `SCE_OFF_STAT, 0, {1'b0, (32'h1 << `SCE_STAT_ACT_BIT) | (32'h1 << `SCE_STAT_EDGE_BIT) |
      (32'h1 << `SCE_STAT_SGL_BIT) | (32'h1 << `SCE_STAT_BUSY_BIT) | (32'h1 << `SCE_STAT_CAL_BIT)});
    acc(0, `SCE_OFF_SENSE, 0, {1'b0, 32'h1});
    m.settle(0, 1);
    m.ovl_q(2'h1);
    pins(4'b1101);
    m.edge_q(2'h0);
    pins(4'b1100);
    m.settle(0, 1);
    m.ovl_q(2'h2);
    pins(4'b1000);
    m.ovl_q(2'h1);
    m.edge_q(2'h2);
    pins(4'b1110);
    m.settle(0, 0);
    m.edge_q(2'h1);
    pins(4'b1110);
    m.settle(0, 0);
    m.power(0, 0);
    pins(4'b1000);
    m.power(1, 0);
    m.win_q({2'h2, 2'h1, 2'h2});
    pins(4'b1001);
    m.settle(1, 0);
    m.win_q({2'h2, 2'h2, 2'h2});
    pins(4'b1010);
    m.settle(1, 0);
    m.power(0, 0);
    @(posedge pclk);
    conclude();
  end
endmodule // tb

// ---- verilog/sce_sync.sv ----
// Purpose: Two-flop synchronisers and edge detection for pin inputs
// Assumes: inputs asynchronous to pclk
// Notes: Edges come from the second and third stages only
`timescale 1ns/100ps
module sce_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw pins: act, query, overlap query, mode, sense[1:0]
  input wire logic [5:0] pins,
  // Synchronised side
  sce_sync_if.src sy
);
  logic [5:0] s1_reg;
  logic [5:0] s2_reg;
  logic [5:0] s3_reg;
  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_reg[i] <= 1'b0;
          s2_reg[i] <= 1'b0;
          s3_reg[i] <= 1'b0;
        end else begin
          s1_reg[i] <= pins[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
        end
      end
    end
  endgenerate
  assign sy.act = s2_reg[0];
  assign sy.act_rise = s2_reg[0] & ~s3_reg[0];
  assign sy.act_fall = ~s2_reg[0] & s3_reg[0];
  assign sy.query = s2_reg[1];
  assign sy.query_rise = s2_reg[1] & ~s3_reg[1];
  assign sy.query_fall = ~s2_reg[1] & s3_reg[1];
  assign sy.ovl_rise = s2_reg[2] & ~s3_reg[2];
  assign sy.mode = s2_reg[3];
  assign sy.sense = s2_reg[5:4];
endmodule // sce_sync

// ---- verilog/sce_top.sv ----
// Purpose: Sheet count evaluator with APB status and control
// Assumes: sense[1:0] carries the measured sheet count (0 none, 1 one, 2 two)
// Notes: All pin inputs are synchronised before use
//
// Behaviour
// - No sheet results are produced until the calibrated flag is set.
// - A primary query drives results from the current sheet measurement.
// - Exactly one sheet at a query drives the single-sheet output high.
// - Two sheets set the multi-sheet output within 2 ms of the query.
// - Double-sheet fault stays latched until activation goes low.
// - While the double fault is latched, query evaluation is suppressed.
// - An overlap query finding only one sheet sets the overlap fault.
// - Overlap fault clears on a later good overlap query or deactivation.
// - Overlap fault never blocks primary query evaluation.
// - Mode select is sampled only on the rise of activation.
// - Edge mode checks on each query rise outside a running 2 ms measurement and passes the result at once.
// - Mode sampled low at activation selects window evaluation.
// - Any single-sheet reading during a window suppresses double indication.
// - Activation level alone selects activated or deactivated state.
`timescale 1ns/100ps
`include "sce_defs.svh"
module sce_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Machine control pins
  input wire logic activate_in,
  input wire logic primary_query_in,
  input wire logic overlap_query_in,
  input wire logic edge_mode_in,
  // Measured sheet count from the sensor front end
  input wire logic [1:0] sheet_sense_in,
  // Result pins
  output logic single_sheet_out,
  output logic double_sheet_out,
  output logic overlap_fault_out,
  output logic ready_out
);
  // Counter spans the whole 2 ms interval at the pclk rate
  localparam logic [14:0] MEAS_CYC = 15'(`SCE_MEAS_CYC);

  // ****************************************
  // Input synchronisation
  // ****************************************
  sce_sync_if sy ();
  sce_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins({sheet_sense_in, edge_mode_in, overlap_query_in, primary_query_in, activate_in}),
    .sy(sy)
  );

  // ****************************************
  // APB register file
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [31:0] prdata_next;
  logic pslverr_next;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_ctrl = (paddr == `SCE_OFF_CTRL);
  wire hit_stat = (paddr == `SCE_OFF_STAT);
  wire hit_sense = (paddr == `SCE_OFF_SENSE);
  wire hit_any = hit_ctrl | hit_stat | hit_sense;
  wire wr_ctrl = access & pwrite & hit_ctrl;
  wire calibrated = ctrl_reg[`SCE_CTRL_CAL_BIT];

  // ****************************************
  // Evaluation state
  // ****************************************
  sce_pkg::sce_state_t state_reg;
  sce_pkg::sce_state_t state_next;
  logic [14:0] cnt_reg;
  logic [14:0] cnt_next;
  logic edge_mode_reg;
  logic edge_mode_next;
  logic dbl_reg;
  logic dbl_next;
  logic sgl_reg;
  logic sgl_next;
  logic ovl_reg;
  logic ovl_next;
  logic win_single_reg;
  logic win_single_next;
  logic win_double_reg;
  logic win_double_next;
  logic ready_reg;

  wire active = sy.act;
  wire enabled = active & ready_reg & ~dbl_reg;
  wire sense_one = (sy.sense == sce_pkg::SCE_ONE);
  wire sense_two = (sy.sense == sce_pkg::SCE_TWO);
  wire cnt_done = (cnt_reg == 15'h0000);
  wire ovl_query = enabled & sy.ovl_rise;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = {31'h00000000, pwdata[`SCE_CTRL_CAL_BIT]};
    end
  end

  always_comb begin
    prdata_next = 32'h00000000;
    pslverr_next = 1'b0;
    if (setup & ~pwrite & hit_ctrl) begin
      prdata_next = ctrl_reg;
    end else if (setup & ~pwrite & hit_stat) begin
      prdata_next[`SCE_STAT_ACT_BIT] = active;
      prdata_next[`SCE_STAT_EDGE_BIT] = edge_mode_reg;
      prdata_next[`SCE_STAT_DBL_BIT] = dbl_reg;
      prdata_next[`SCE_STAT_SGL_BIT] = sgl_reg;
      prdata_next[`SCE_STAT_OVL_BIT] = ovl_reg;
      prdata_next[`SCE_STAT_BUSY_BIT] = ~state_reg[0];
      prdata_next[`SCE_STAT_CAL_BIT] = ready_reg;
    end else if (setup & ~pwrite & hit_sense) begin
      prdata_next = {30'h00000000, sy.sense};
    end
    if (setup & ~hit_any) begin
      pslverr_next = 1'b1;
    end else if (setup & pwrite & ~hit_ctrl) begin
      pslverr_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SCE_CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ****************************************
  // Bus answer, one access cycle after every setup
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= setup ? prdata_next : prdata_reg;
      pready_reg <= setup;
      pslverr_reg <= setup ? pslverr_next : 1'b0;
    end
  end

  // ****************************************
  // Measurement sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    edge_mode_next = edge_mode_reg;
    dbl_next = dbl_reg;
    sgl_next = sgl_reg;
    win_single_next = win_single_reg;
    win_double_next = win_double_reg;
    if (sy.act_rise) begin
      edge_mode_next = sy.mode;
    end
    case (state_reg)
      sce_pkg::SCE_IDLE: begin
        if (enabled & sy.query_rise & edge_mode_reg) begin
          state_next = sce_pkg::SCE_MEAS;
          cnt_next = MEAS_CYC - 15'h0001;
          sgl_next = sense_one;
          if (sense_two) begin
            dbl_next = 1'b1;
          end
        end else if (enabled & sy.query_fall & ~edge_mode_reg) begin
          state_next = sce_pkg::SCE_WIN;
          win_single_next = sense_one;
          win_double_next = sense_two;
        end
      end
      sce_pkg::SCE_MEAS: begin
        if (!enabled) begin
          state_next = sce_pkg::SCE_IDLE;
        end else begin
          sgl_next = sense_one;
          if (sense_two) begin
            dbl_next = 1'b1;
          end
          if (cnt_done) begin
            state_next = sce_pkg::SCE_IDLE;
          end else begin
            cnt_next = cnt_reg - 15'h0001;
          end
        end
      end
      sce_pkg::SCE_WIN: begin
        if (!enabled) begin
          state_next = sce_pkg::SCE_IDLE;
        end else if (sy.query_rise) begin
          state_next = sce_pkg::SCE_IDLE;
          sgl_next = win_single_reg | sense_one;
          if (win_double_reg & ~win_single_reg & ~sense_one) begin
            dbl_next = 1'b1;
          end
        end else begin
          win_single_next = win_single_reg | sense_one;
          win_double_next = win_double_reg | sense_two;
        end
      end
      default: begin
        state_next = sce_pkg::SCE_IDLE;
      end
    endcase
    // Deactivation overrides the double, single and state next values
    if (!active) begin
      dbl_next = 1'b0;
      sgl_next = 1'b0;
      state_next = sce_pkg::SCE_IDLE;
    end
  end

  // ****************************************
  // Overlap fault
  // ****************************************
  // Set wins over clear when both fall in one cycle
  always_comb begin
    ovl_next = ovl_reg;
    if (ovl_query & sense_one) begin
      ovl_next = 1'b1;
    end else if (ovl_query & sense_two) begin
      ovl_next = 1'b0;
    end else if (!active) begin
      ovl_next = 1'b0;
    end
  end

  // ****************************************
  // Mode capture
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_mode_reg <= 1'b0;
    end else begin
      edge_mode_reg <= edge_mode_next;
    end
  end

  // ****************************************
  // Sequencer registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= sce_pkg::SCE_IDLE;
      cnt_reg <= 15'h0000;
      win_single_reg <= 1'b0;
      win_double_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      win_single_reg <= win_single_next;
      win_double_reg <= win_double_next;
    end
  end

  // ****************************************
  // Result latches
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbl_reg <= 1'b0;
      sgl_reg <= 1'b0;
      ovl_reg <= 1'b0;
    end else begin
      dbl_reg <= dbl_next;
      sgl_reg <= sgl_next;
      ovl_reg <= ovl_next;
    end
  end

  // ****************************************
  // Calibrated flag
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= calibrated;
    end
  end

  // ****************************************
  // Output flops
  // ****************************************
  // Outputs take the next values so pins move in the cycle after a decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_sheet_out <= 1'b0;
    end else begin
      single_sheet_out <= sgl_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_sheet_out <= 1'b0;
    end else begin
      double_sheet_out <= dbl_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overlap_fault_out <= 1'b0;
    end else begin
      overlap_fault_out <= ovl_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_out <= 1'b0;
    end else begin
      ready_out <= calibrated;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule // sce_top
